/* core/fp_special_round.sv */
// single precision class decode, rounding and exception status core
// assumes an AXI4-Lite master with one write and one read in flight at most
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`include "fp_regs.svh"
module fp_special_round #(
   parameter int ADDR_W = 8
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready
);
   logic [31:0] opa_q, opb_q, res_q, wdat_q, rdata_q;
   logic [5:0]  func_q;
   logic [3:0]  status_output_register_q, flg_q, wstb_q;
   logic [7:0]  waddr_q;
   logic        go_q, done_q, aw_full_q, w_full_q, bvalid_q, rvalid_q;
   logic [1:0]  bresp_q, rresp_q;

   // leading zero count over the working mantissa
   function automatic logic [5:0] lzc48(input logic [47:0] v);
      logic [5:0] k;
      k = 6'd48;
      for (int i = 0; i < 48; i++) begin
         if (v[i]) k = 6'(47 - i);
      end
      return k;
   endfunction

   // right shift folding lost bits into bit 0
   function automatic logic [47:0] shr_st(input logic [47:0] v, input logic [10:0] n);
      logic [47:0] r;
      logic        st;
      if (n >= 11'd48) begin
         r  = '0;
         st = |v;
      end else begin
         r  = v >> n;
         st = |(v & ~({48{1'b1}} << n));
      end
      return {r[47:1], r[0] | st};
   endfunction

   // increment decision for each rounding mode
   function automatic logic rnd_up(input fp_pkg::rnd_t m, input logic s, input logic lsb,
                                   input logic g, input logic st);
      logic u;
      unique case (m)
         fp_pkg::round_nearest_even: u = g & (st | lsb);
         fp_pkg::round_toward_zero:  u = 1'b0;
         fp_pkg::round_toward_plus:  u = ~s & (g | st);
         fp_pkg::round_toward_minus: u = s & (g | st);
      endcase
      return u;
   endfunction

   // order key: larger key means larger value, zeros share one key
   function automatic logic [31:0] cmp_key(input logic [31:0] v);
      return (v[30:0] == 31'h0) ? 32'h80000000 : (v[31] ? ~v : {1'b1, v[30:0]});
   endfunction

   // per-operation selection from the function word
   wire fp_pkg::op_t  op   = fp_pkg::op_t'(func_q[`FUNC_OP_LSB +: 3]);
   wire fp_pkg::rnd_t rnd  = fp_pkg::rnd_t'(func_q[`FUNC_RND_LSB +: 2]);
   wire               fast = func_q[`FUNC_FAST_BIT];

   // operand decode; fast mode drops denormal fractions
   wire        sa = opa_q[31];
   wire        sb = opb_q[31];
   wire [7:0]  ea = opa_q[30:23];
   wire [7:0]  eb = opb_q[30:23];
   wire [22:0] fa = (fast && ea == 8'h00) ? 23'h0 : opa_q[22:0];
   wire [22:0] fb = (fast && eb == 8'h00) ? 23'h0 : opb_q[22:0];
   wire        za = ea == 8'h00 && fa == 23'h0;
   wire        zb = eb == 8'h00 && fb == 23'h0;
   wire        da = ea == 8'h00 && fa != 23'h0;
   wire        db = eb == 8'h00 && fb != 23'h0;
   wire        ia = ea == 8'hFF && fa == 23'h0;
   wire        ib = eb == 8'hFF && fb == 23'h0;
   wire        nan_a = ea == 8'hFF && fa != 23'h0;
   wire        use_b = op == fp_pkg::op_add || op == fp_pkg::op_sub
                    || op == fp_pkg::op_mul || op == fp_pkg::op_cmp;
   wire        nan_b = use_b && eb == 8'hFF && fb != 23'h0;
   wire        sbe = sb ^ (op == fp_pkg::op_sub);
   wire [23:0] ma = {ea != 8'h00, fa};
   wire [23:0] mb = {eb != 8'h00, fb};
   wire signed [10:0] xa = (ea == 8'h00) ? 11'sd1 : $signed({3'b0, ea});
   wire signed [10:0] xb = (eb == 8'h00) ? 11'sd1 : $signed({3'b0, eb});
   wire        a_big = xa > xb || (xa == xb && ma >= mb);

   logic [47:0]        nm, hi, lo, nn, mant, fxr;
   logic [63:0]        fx;
   logic signed [10:0] rx, ex, ef, sh;
   logic [5:0]         k;
   logic [24:0]        sum;
   logic [32:0]        mag;
   logic [31:0]        res_c;
   logic [3:0]         st_c, cmp_c;
   logic               rs, tiny, up, xst, lost, inx_c, unf_c, ovf_c, inv_c, den_c;
   logic               wrapped_unf;

   // main datapath: align/multiply, normalise, round, then specials
   always_comb begin
      nm = '0; hi = '0; lo = '0; nn = '0; mant = '0; fxr = '0; fx = '0;
      rx = '0; ex = '0; ef = '0; sh = '0; k = '0; sum = '0; mag = '0;
      rs = sa; tiny = 1'b0; up = 1'b0; lost = 1'b0; wrapped_unf = 1'b0;
      xst = (op == fp_pkg::op_unwrap_inexact);
      inx_c = 1'b0; unf_c = 1'b0; ovf_c = 1'b0; inv_c = 1'b0;
      den_c = 1'b0; cmp_c = `ST_EQUAL; res_c = `NAN_VAL;
      unique case (op)
         fp_pkg::op_add, fp_pkg::op_sub: begin
            hi = a_big ? {1'b0, ma, 23'h0} : {1'b0, mb, 23'h0};
            lo = shr_st(a_big ? {1'b0, mb, 23'h0} : {1'b0, ma, 23'h0},
                        11'(a_big ? xa - xb : xb - xa));
            rs = a_big ? sa : sbe;
            rx = (a_big ? xa : xb) + 11'sd1;
            nm = (sa == sbe) ? hi + lo : hi - lo;
         end
         fp_pkg::op_mul: begin
            nm = ma * mb;
            rs = sa ^ sb;
            rx = xa + xb - 11'sd126;
            den_c = !fast && (da || db);
         end
         fp_pkg::op_wrap: begin
            nm = {ma, 24'h0};
            rx = xa;
         end
         fp_pkg::op_unwrap_exact, fp_pkg::op_unwrap_inexact: begin
            nm = {1'b1, fa, 24'h0};
            rx = $signed({{3{ea[7]}}, ea});  // wrapped exponent is two's complement
         end
         fp_pkg::op_cmp, fp_pkg::op_fix: nm = '0;
      endcase
      k = lzc48(nm);
      nn = nm << k;
      ex = rx - $signed({5'b0, k});
      tiny = ex < 11'sd1;
      mant = tiny ? shr_st(nn, 11'(11'sd1 - ex)) : nn;
      up = rnd_up(rnd, rs, mant[24], mant[23], |mant[22:0] | xst);
      sum = {1'b0, mant[47:24]} + {24'h0, up};
      ef = tiny ? 11'sd0 : ex;
      if (sum[24]) begin
         ef = ef + 11'sd1;
         sum = {1'b0, sum[24:1]};
      end else if (tiny && sum[23]) begin
         ef = 11'sd1;
      end
      if (op == fp_pkg::op_wrap) begin
         res_c = {rs, ex[7:0], nn[46:24]};
      end else if (nm == 48'h0) begin
         // exact zero keeps its sign unless opposite signs meet in a sum or difference
         res_c = {(op != fp_pkg::op_mul && sa != sbe) ? (rnd == fp_pkg::round_toward_minus)
                  : rs, 31'h0};
      end else if (tiny && fast) begin
         res_c = {rs, 31'h0};
         unf_c = 1'b1;
         inx_c = 1'b1;
      end else if (tiny && op == fp_pkg::op_mul) begin
         wrapped_unf = 1'b1;
         res_c = {rs, ex[7:0], nn[46:24]};
         unf_c = 1'b1;
         inx_c = |nn[23:0];
      end else if (ef >= 11'sd255) begin
         ovf_c = 1'b1;
         inx_c = 1'b1;
         if (rs ? (rnd == fp_pkg::round_toward_plus || rnd == fp_pkg::round_toward_zero)
                : (rnd == fp_pkg::round_toward_minus || rnd == fp_pkg::round_toward_zero))
            res_c = {rs, `MAXNRM_MAG};
         else
            res_c = {rs, `INF_MAG};
      end else begin
         res_c = {rs, ef[7:0], sum[22:0]};
         inx_c = mant[23] | (|mant[22:0]) | xst;
         unf_c = ef == 11'sd0 && (sum[22:0] != 23'h0 || inx_c);
      end
      // float to integer conversion
      if (op == fp_pkg::op_fix) begin
         sh = xa - 11'sd118;
         if (sh >= 11'sd0) begin
            fx = {40'h0, ma} << sh[5:0];
         end else if (sh < -11'sd63) begin
            lost = |ma;
         end else begin
            fx = {40'h0, ma} >> 6'(-sh);
            lost = |({40'h0, ma} & ~({64{1'b1}} << 6'(-sh)));
         end
         up = rnd_up(rnd, sa, fx[32], fx[31], |fx[30:0] | lost);
         mag = {1'b0, fx[63:32]} + {32'h0, up};
         inx_c = fx[31] | (|fx[30:0]) | lost;
         unf_c = 1'b0;
         if (ia || ea > 8'd158 || mag > (sa ? 33'h080000000 : 33'h07FFFFFFF)) begin
            ovf_c = 1'b1;
            inx_c = 1'b1;
            res_c = sa ? `INT_MIN : `INT_MAX;
         end else begin
            res_c = sa ? 32'(-mag) : mag[31:0];
            ovf_c = 1'b0;
         end
      end
      // compare outcome
      if (nan_a || nan_b)
         cmp_c = `ST_INVALID;
      else if (cmp_key(opa_q) == cmp_key(opb_q) || (za && zb))
         cmp_c = `ST_EQUAL;
      else if (cmp_key({sa, ea, fa}) < cmp_key({sb, eb, fb}))
         cmp_c = `ST_LESS;
      else
         cmp_c = `ST_GREATER;
      // infinities and invalid combinations override the arithmetic
      if (op == fp_pkg::op_add || op == fp_pkg::op_sub || op == fp_pkg::op_mul) begin
         if (op == fp_pkg::op_mul ? ((ia || ib) && (za || zb)) : (ia && ib && sa != sbe)) begin
            inv_c = 1'b1;
            res_c = `NAN_VAL;
         end else if (ia || ib) begin
            res_c = {op == fp_pkg::op_mul ? rs : (ia ? sa : sbe), `INF_MAG};
         end
         if (ia || ib) begin
            inx_c = 1'b0;
            unf_c = 1'b0;
            ovf_c = 1'b0;
         end
      end
      // a not-a-number result carries no overflow, underflow or inexact meaning
      if (nan_a || nan_b) begin
         inv_c = 1'b1;
         res_c = `NAN_VAL;
         inx_c = 1'b0;
         unf_c = 1'b0;
         ovf_c = 1'b0;
      end
   end

   // four-bit status by priority; compare outcome wins
   always_comb begin
      if (op == fp_pkg::op_cmp)           st_c = cmp_c;
      else if (nan_a && nan_b)            st_c = `ST_NAN_AB;
      else if (nan_a)                     st_c = `ST_NAN_A;
      else if (nan_b)                     st_c = `ST_NAN_B;
      else if (inv_c)                     st_c = `ST_INVALID;
      else if (den_c && da && db)         st_c = `ST_DEN_AB;
      else if (den_c && da)               st_c = `ST_DEN_A;
      else if (den_c)                     st_c = `ST_DEN_B;
      else if (unf_c)                     st_c = inx_c ? `ST_UNF_INX : `ST_UNF;
      else if (ovf_c)                     st_c = `ST_OVF_INX;
      else if (inx_c)                     st_c = `ST_INEXACT;
      else if (res_c[30:0] == 31'h0)      st_c = `ST_EQUAL;
      else if (res_c[30:0] == `INF_MAG)   st_c = `ST_INF;
      else                                st_c = `ST_FINITE;
   end

   // bus handshakes and decode
   wire       aw_hs = awvalid && awready;
   wire       w_hs  = wvalid && wready;
   wire       wr_fire = aw_full_q && w_full_q;
   wire       ar_hs = arvalid && arready;
   wire [7:0] ra = 8'(araddr);
   wire       wr_ok = waddr_q == `OFS_OPA || waddr_q == `OFS_OPB || waddr_q == `OFS_FUNC;
   wire       rd_ok = ra == `OFS_RESULT || ra == `OFS_STATUS || ra == `OFS_OPA
                   || ra == `OFS_OPB || ra == `OFS_FUNC;
   wire [31:0] wmask = {{8{wstb_q[3]}}, {8{wstb_q[2]}}, {8{wstb_q[1]}}, {8{wstb_q[0]}}};
   wire [31:0] rd_mux =
      (ra == `OFS_OPA)    ? opa_q :
      (ra == `OFS_OPB)    ? opb_q :
      (ra == `OFS_FUNC)   ? {26'h0, func_q} :
      (ra == `OFS_RESULT) ? res_q :
      (ra == `OFS_STATUS) ? {23'h0, done_q, flg_q, status_output_register_q} : 32'h0;
   assign awready = !aw_full_q && !bvalid_q;
   assign wready  = !w_full_q && !bvalid_q;
   assign arready = !rvalid_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;

   // write channels are held until both halves arrived
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `RESP_OKAY;
         waddr_q   <= 8'h00;
         wdat_q    <= 32'h0;
         wstb_q    <= 4'h0;
      end else begin
         if (aw_hs) begin
            aw_full_q <= 1'b1;
            waddr_q   <= 8'(awaddr);
         end
         if (w_hs) begin
            w_full_q <= 1'b1;
            wdat_q   <= wdata;
            wstb_q   <= wstrb;
         end
         if (wr_fire) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // operand and function registers; a function write launches the operation
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         opa_q  <= 32'h0;
         opb_q  <= 32'h0;
         func_q <= `FUNC_RST;
         go_q   <= 1'b0;
      end else begin
         go_q <= wr_fire && waddr_q == `OFS_FUNC;
         if (wr_fire && waddr_q == `OFS_OPA)  opa_q <= (opa_q & ~wmask) | (wdat_q & wmask);
         if (wr_fire && waddr_q == `OFS_OPB)  opb_q <= (opb_q & ~wmask) | (wdat_q & wmask);
         if (wr_fire && waddr_q == `OFS_FUNC && wstb_q[0]) func_q <= wdat_q[5:0];
      end
   end

   // result and status enter the output registers on the same edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         res_q <= 32'h0;
         status_output_register_q <= `ST_EQUAL;
         flg_q  <= 4'h0;
         done_q <= 1'b0;
      end else if (go_q) begin
         res_q <= res_c;
         status_output_register_q <= st_c;
         flg_q  <= {inv_c, ovf_c, unf_c, inx_c};
         done_q <= 1'b1;
      end else if (wr_fire && waddr_q == `OFS_FUNC) begin
         done_q <= 1'b0;
      end
   end

   // read channel, one beat per request
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0;
         rresp_q  <= `RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_mux;
         rresp_q  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rready) begin
         rvalid_q <= 1'b0;
      end
   end

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_status_step;
      go_q |=> done_q && status_output_register_q == $past(st_c) && res_q == $past(res_c);
   endproperty
   a_status_step: assert property (p_status_step) else $error("status not in step");
   property p_cmp_code;
      go_q && op == fp_pkg::op_cmp |=> status_output_register_q inside {4'h0, 4'h1, 4'h2, 4'hF};
   endproperty
   a_cmp_code: assert property (p_cmp_code) else $error("bad compare code");
   property p_nan_first;
      go_q && nan_a && op != fp_pkg::op_cmp |=> status_output_register_q inside {4'hC, 4'hE}
                                             && res_q == `NAN_VAL;
   endproperty
   a_nan_first: assert property (p_nan_first) else $error("nan not reported");
   property p_fast_flush;
      go_q && fast && unf_c |=> res_q[30:0] == 31'h0 && flg_q[1];
   endproperty
   a_fast_flush: assert property (p_fast_flush) else $error("fast underflow not zero");
   property p_zero_no_unf;
      go_q && nm == 48'h0 && op != fp_pkg::op_fix && op != fp_pkg::op_cmp |=> !flg_q[1];
   endproperty
   a_zero_no_unf: assert property (p_zero_no_unf) else $error("underflow on zero");
   property p_ovf_rz;
      go_q && ovf_c && op != fp_pkg::op_fix && rnd == fp_pkg::round_toward_zero
      |=> res_q[30:0] == `MAXNRM_MAG && status_output_register_q inside {4'h5, 4'hF, 4'hC, 4'hD};
   endproperty
   a_ovf_rz: assert property (p_ovf_rz) else $error("toward zero overflow not max");
   property p_wrap_sticky;
      go_q && wrapped_unf |=> status_output_register_q[0] == $past(|nn[23:0]);
   endproperty
   a_wrap_sticky: assert property (p_wrap_sticky) else $error("wrap sticky wrong");
   property p_zero_inf;
      go_q && op == fp_pkg::op_mul && ia && zb && !nan_b |=> res_q == `NAN_VAL && flg_q[3];
   endproperty
   a_zero_inf: assert property (p_zero_inf) else $error("zero times inf valid");
   property p_fix_range;
      go_q && op == fp_pkg::op_fix && !nan_a && ea > 8'd158 |=> flg_q[2];
   endproperty
   a_fix_range: assert property (p_fix_range) else $error("fix overflow missed");
endmodule // fp_special_round

/* core/fp_regs.svh */
// register offsets, field positions, reset values and special encodings
// assumes single precision words on a 32-bit AXI4-Lite register bus
// Functional notes
// - zero: exponent 0, fraction 0, both signs
// - exponent 0, nonzero fraction is denormal
// - host wraps denormals before multiplying them
// - wrap shifts fraction left, exponent one minus shifts
// - IEEE mode: tiny products become wrapped values; tiny sums stay denormal
// - all-ones exponent, nonzero fraction is not-a-number
// - nearest rounding, ties go to even
// - toward zero never grows the magnitude
// - toward plus never below exact value
// - toward minus never above exact value
// - fast mode flushes underflow to zero
// - IEEE mode multiplier wraps underflow, no rounding
// - wrapped multiply underflow: lsb status is sticky
// - status travels with result into output register
// - compare outcome overrides exception status
// - guard bits set inexact, also lossy fix
// - underflow when tiny, never for exact zero
// - overflow gives max normal or infinity by mode
// - fix overflow beyond 32-bit integer
// - nan operand, zero times inf, inf minus inf invalid
// - opposite zeros sum positive, negative toward minus
// - four-bit status codes for compare and exceptions
// - highest priority exception shown
`ifndef FP_REGS_SVH
`define FP_REGS_SVH
`define OFS_OPA        8'h00
`define OFS_OPB        8'h04
`define OFS_FUNC       8'h08
`define OFS_RESULT     8'h0C
`define OFS_STATUS     8'h10
`define FUNC_OP_LSB    0
`define FUNC_RND_LSB   3
`define FUNC_FAST_BIT  5
`define FUNC_RST       6'h00
`define NAN_VAL        32'h7FFFFFFF
`define MAXNRM_MAG     31'h7F7FFFFF
`define INF_MAG        31'h7F800000
`define INT_MAX        32'h7FFFFFFF
`define INT_MIN        32'h80000000
`define ST_EQUAL       4'h0
`define ST_LESS        4'h1
`define ST_GREATER     4'h2
`define ST_INF         4'h1
`define ST_FINITE      4'h2
`define ST_INEXACT     4'h3
`define ST_OVF_INX     4'h5
`define ST_UNF         4'h6
`define ST_UNF_INX     4'h7
`define ST_DEN_A       4'h8
`define ST_DEN_B       4'h9
`define ST_DEN_AB      4'hA
`define ST_NAN_A       4'hC
`define ST_NAN_B       4'hD
`define ST_NAN_AB      4'hE
`define ST_INVALID     4'hF
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

/* core/fp_pkg.sv */
// types shared by the floating-point special operand core
// assumes the offsets and codes come from fp_regs.svh
package fp_pkg;
   typedef enum logic [2:0] {
      op_add = 3'h0, op_sub = 3'h1, op_mul = 3'h2, op_cmp = 3'h3,
      op_wrap = 3'h4, op_unwrap_exact = 3'h5, op_unwrap_inexact = 3'h6, op_fix = 3'h7
   } op_t;
   typedef enum logic [1:0] {
      round_nearest_even = 2'h0, round_toward_zero = 2'h1,
      round_toward_plus = 2'h2, round_toward_minus = 2'h3
   } rnd_t;
endpackage

/* verification/fp_host_model.sv */
// host sequencer model: AXI4-Lite master with one write and one read task
// assumes one shared rising-edge clock; a wait past its bound raises hung
module fp_host_model (
   input  wire logic        aclk,
   input  wire logic        awready,
   input  wire logic        wready,
   input  wire logic        bvalid,
   input  wire logic        arready,
   input  wire logic        rvalid,
   input  wire logic [1:0]  bresp,
   input  wire logic [1:0]  rresp,
   input  wire logic [31:0] rdata,
   output logic             awvalid,
   output logic             wvalid,
   output logic             bready,
   output logic             arvalid,
   output logic             rready,
   output logic             hung,
   output logic [7:0]       awaddr,
   output logic [7:0]       araddr,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle bus at time zero
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, hung} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
   end
   // write: both channels offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      {awaddr, wdata, wstrb} <= {a, d, 4'hF};
      {awvalid, wvalid, bready} <= 3'h7;
      r = 2'h3;
      for (int n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wvalid && wready) wdata <= ~d; // released data must not look valid
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            bready <= 1'b0;
            return;
         end
      end
      hung = 1'b1;
   endtask
   // read: address held until taken, rready held until the answer
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      {d, r} = '1;
      for (int n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            {d, r} = {rdata, rresp};
            rready <= 1'b0;
            return;
         end
      end
      hung = 1'b1;
   endtask
endmodule // fp_host_model

/* verification/fp_special_round_tb.sv */
// self-checking bench: operand, function and status traffic over AXI4-Lite
// assumes fp_host_model as the bus master and single precision operands
module fp_special_round_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, hung;
   logic        arvalid, arready, rvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, e;
   int          n_errors = 0;
   int          checks = 0;
   // 125 MHz clock
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   fp_special_round fp_special_round_i (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
   );
   fp_host_model fp_host_model_i (
      .aclk(aclk), .awready(awready), .wready(wready), .bvalid(bvalid), .arready(arready),
      .rvalid(rvalid), .bresp(bresp), .rresp(rresp), .rdata(rdata), .awvalid(awvalid),
      .wvalid(wvalid), .bready(bready), .arvalid(arvalid), .rready(rready), .hung(hung),
      .awaddr(awaddr), .araddr(araddr), .wdata(wdata), .wstrb(wstrb)
   );
   // verdict and end of run
   task automatic summarize();
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // compare; a hung bus ends the run at once
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
      checks++;
      if (hung !== 1'b0) begin
         n_errors++;
         $display("mismatch bus_answer expected %h seen %h", 1'b0, hung);
      end
      if (y !== x) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, x, y);
      end
      if (hung !== 1'b0) summarize();
   endtask
   // flag bits {invalid, overflow, underflow, inexact} implied by a status code;
   // denormal codes assume an exact product underneath
   function automatic logic [3:0] flg_of(input logic [3:0] s);
      case (s)
         4'h3:                   return 4'h1;
         4'h5:                   return 4'h5;
         4'h6:                   return 4'h2;
         4'h7:                   return 4'h3;
         4'hC, 4'hD, 4'hE, 4'hF: return 4'h8;
         default:                return 4'h0;
      endcase
   endfunction
   // one operation; compare leaves the result word unchecked
   task automatic t(input logic [31:0] a, input logic [31:0] b, input logic [5:0] f,
                    input logic [31:0] r, input logic [3:0] s);
      fp_host_model_i.wr(8'h00, a, e);
      fp_host_model_i.wr(8'h04, b, e);
      fp_host_model_i.wr(8'h08, {26'h0, f}, e);
      fp_host_model_i.rd(8'h0C, d, e);
      if (f[2:0] != 3'h3) chk("result", r, d);
      fp_host_model_i.rd(8'h10, d, e);
      chk("status", {23'h0, 1'b1, flg_of(s), s}, {23'h0, d[8:0]});
   endtask
   // main sequence: bus access, then operations by mode
   initial begin
      aresetn = 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      fp_host_model_i.rd(8'h08, d, e);
      chk("func reset", 32'h0, d);
      fp_host_model_i.wr(8'h08, 32'h1B, e);
      fp_host_model_i.rd(8'h08, d, e);
      chk("func", 32'h1B, d);
      fp_host_model_i.wr(8'h0C, 32'h1, e);
      chk("bresp", 32'h2, {30'h0, e});
      fp_host_model_i.rd(8'h14, d, e);
      chk("unmapped", 32'h2, {d[29:0], e});
      t(32'h0,32'h80000000,6'h00,32'h0,4'h0);
      t(32'h0,32'h80000000,6'h18,32'h80000000,4'h0);
      t(32'h3F800000,32'h33800000,6'h00,32'h3F800000,4'h3);
      t(32'h3F800000,32'h34400000,6'h00,32'h3F800002,4'h3);
      t(32'h3F800000,32'h34400000,6'h08,32'h3F800001,4'h3);
      t(32'h3F800000,32'h33800000,6'h10,32'h3F800001,4'h3);
      t(32'hBF800000,32'hB3800000,6'h18,32'hBF800001,4'h3);
      t(32'h3F800000,32'h33800000,6'h01,32'h3F7FFFFF,4'h2);
      t(32'h7F7FFFFF,32'h40000000,6'h02,32'h7F800000,4'h5);
      t(32'h7F7FFFFF,32'h40000000,6'h0A,32'h7F7FFFFF,4'h5);
      t(32'hFF7FFFFF,32'h40000000,6'h12,32'hFF7FFFFF,4'h5);
      t(32'h7F800000,32'h7F800000,6'h01,32'h7FFFFFFF,4'hF);
      t(32'h7F800000,32'h0,6'h02,32'h7FFFFFFF,4'hF);
      t(32'h7FC00000,32'h3F800000,6'h00,32'h7FFFFFFF,4'hC);
      t(32'h7FC00000,32'h7FC00000,6'h00,32'h7FFFFFFF,4'hE);
      t(32'h3F800000,32'h40000000,6'h03,32'h0,4'h1);
      t(32'h7FC00000,32'h3F800000,6'h03,32'h0,4'hF);
      t(32'h4F000000,32'h0,6'h07,32'h7FFFFFFF,4'h5);
      t(32'h4F800000,32'h0,6'h07,32'h7FFFFFFF,4'h5);
      t(32'h3FC00000,32'h0,6'h07,32'h2,4'h3);
      t(32'h80000001,32'h0,6'h04,32'hF5000000,4'h2);
      t(32'hF5000000,32'h0,6'h05,32'h80000001,4'h6);
      t(32'hF5000000,32'h0,6'h06,32'h80000001,4'h7);
      t(32'h0D800000,32'h0D800000,6'h02,32'h5B800000,4'h6);
      t(32'h0D800001,32'h0D800001,6'h02,32'h5B800002,4'h7);
      t(32'h00400000,32'h7E800000,6'h02,32'h3F000000,4'h8);
      t(32'h0D800000,32'h0D800000,6'h22,32'h0,4'h7);
      t(32'h80000001,32'h80000000,6'h20,32'h80000000,4'h0);
      t(32'h00800001,32'h00800000,6'h01,32'h1,4'h6);
      t(32'h00800000,32'h00800000,6'h01,32'h0,4'h0);
      summarize();
   end
endmodule // fp_special_round_tb
